//--- logic/csw_pkg.sv
package csw_pkg;

  // Mode field layout
  localparam int unsigned MODE_W   = 3;
  localparam int unsigned SEL_BIT  = 2;
  localparam int unsigned CNT_W    = 6;

  // Mode codes
  localparam logic [2:0] MODE_OFF      = 3'h0;
  localparam logic [2:0] MODE_WAKE     = 3'h1;
  localparam logic [2:0] MODE_SEL_WAKE = 3'h5;
  localparam logic [2:0] MODE_RESET    = 3'h0;

  // Transceiver operating codes (low two bits of the field)
  localparam logic [1:0] OP_OFF  = 2'h0;
  localparam logic [1:0] OP_WAKE = 2'h1;

  // Error count shown after a counter overflow wake
  localparam logic [5:0] CNT_OVERFLOW = 6'h20;
  localparam logic [5:0] CNT_RESET    = 6'h00;

  // Device power modes
  typedef enum logic [1:0] {
    CSW_PWR_NORMAL  = 2'b00,
    CSW_PWR_STOP    = 2'b01,
    CSW_PWR_SLEEP   = 2'b10,
    CSW_PWR_RESTART = 2'b11
  } csw_pwr_e;

endpackage : csw_pkg

//--- logic/csw_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module csw_mode_ctrl (
  // Clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  // Power mode commands (one-cycle pulses)
  input  wire logic                       GO_STOP,
  input  wire logic                       GO_SLEEP,
  input  wire logic                       GO_RESTART,
  input  wire logic                       GO_NORMAL,
  // Host settings
  input  wire logic                       MODE_WR,
  input  wire logic [csw_pkg::MODE_W-1:0] MODE_WDATA,
  input  wire logic                       CFG_VALID_SET,
  input  wire logic                       CFG_CHANGED,
  input  wire logic                       ERR_CLR,
  input  wire logic                       WAKE_FLAGS_CLR,
  // Bus wake events (one-cycle pulses)
  input  wire logic                       WAKE_PATTERN,
  input  wire logic                       WAKE_FRAME,
  input  wire logic                       ERR_OVERFLOW,
  input  wire logic                       OTHER_WAKE,
  input  wire logic                       SILENCE_EXPIRED,
  // Mode and status
  output logic [1:0]                      POWER_MODE,
  output logic [csw_pkg::MODE_W-1:0]      MODE_FIELD,
  output logic [1:0]                      XCVR_OP,
  output logic                            XCVR_SEL_WAKE,
  output logic                            XCVR_REARM,
  output logic                            SEL_WAKE_ERR,
  output logic                            CONFIG_VALID,
  output logic                            BUS_WAKE,
  output logic                            WAKE_PAT,
  output logic                            WAKE_FRM,
  output logic [csw_pkg::CNT_W-1:0]       ERR_COUNT
);

  csw_pkg::csw_pwr_e               pwr_reg, pwr_next;
  logic [csw_pkg::MODE_W-1:0]      field_reg, field_next;
  logic [1:0]                      op_reg, op_next;
  logic                            sel_reg, sel_next;
  logic                            rearm_reg, rearm_next;
  logic                            err_reg, err_next;
  logic                            cfg_reg, cfg_next;
  logic                            bus_reg, bus_next;
  logic                            pat_reg, pat_next;
  logic                            frm_reg, frm_next;
  logic [csw_pkg::CNT_W-1:0]       cnt_reg, cnt_next;

  // Decoded views of the stored field and the write data, plus wake and error strobes
  logic field_off;
  logic field_sel;
  logic wr_off;
  logic wr_sel;
  logic err_set;
  logic wake_any;

  assign field_off = (field_reg[1:0] == csw_pkg::OP_OFF);
  assign field_sel = field_reg[csw_pkg::SEL_BIT] && !field_off;
  assign wr_off    = (MODE_WDATA[1:0] == csw_pkg::OP_OFF);
  assign wr_sel    = MODE_WDATA[csw_pkg::SEL_BIT] && !wr_off;
  // Wakes the transceiver can see, plus OTHER_WAKE at all times
  assign wake_any  = (sel_reg && (WAKE_FRAME || ERR_OVERFLOW)) ||
                     (!sel_reg && !field_off && WAKE_PATTERN) || OTHER_WAKE;

  // Next-state computation for the whole block
  always_comb begin
    pwr_next   = pwr_reg;
    field_next = field_reg;
    op_next    = op_reg;
    sel_next   = sel_reg;
    rearm_next = 1'b0;
    err_next   = err_reg;
    cfg_next   = cfg_reg;
    bus_next   = bus_reg;
    pat_next   = pat_reg;
    frm_next   = frm_reg;
    cnt_next   = cnt_reg;
    err_set    = 1'b0;

    // Host clears; a hardware set later in this cycle wins
    if (WAKE_FLAGS_CLR) begin
      bus_next = 1'b0;
    end
    if (CFG_VALID_SET && pwr_reg == csw_pkg::CSW_PWR_NORMAL) begin
      cfg_next = 1'b1;
    end
    // Error clear blocked while selective wake lacks valid data
    if (ERR_CLR && !(field_reg[csw_pkg::SEL_BIT] && !cfg_reg)) begin
      err_next = 1'b0;
    end

    case (pwr_reg)
      csw_pkg::CSW_PWR_NORMAL: begin
        if (MODE_WR) begin
          field_next = MODE_WDATA;
          op_next    = MODE_WDATA[1:0];
          rearm_next = (MODE_WDATA != field_reg);
          pat_next   = rearm_next ? 1'b0 : pat_reg;
          frm_next   = rearm_next ? 1'b0 : frm_reg;
          if (wr_sel) begin
            // Configuration check on enabling selective wake
            err_set  = !cfg_next;
            err_next = !cfg_next;
          end
          sel_next = wr_sel && !err_next;
        end else if (CFG_CHANGED) begin
          cfg_next = 1'b0;
          if (field_sel) begin
            err_set  = 1'b1;
            sel_next = 1'b0;
          end
        end else begin
          sel_next = field_sel && !err_next;
        end

        if (GO_STOP) begin
          pwr_next = csw_pkg::CSW_PWR_STOP;
          op_next  = field_reg[1:0];
          sel_next = field_sel && !err_next;
        end else if (GO_SLEEP) begin
          pwr_next   = csw_pkg::CSW_PWR_SLEEP;
          rearm_next = 1'b1;
          pat_next   = 1'b0;
          frm_next   = 1'b0;
          cnt_next   = csw_pkg::CNT_RESET;
          if (field_off) begin
            op_next  = csw_pkg::OP_OFF;
            sel_next = 1'b0;
          end else if (field_reg[csw_pkg::SEL_BIT]) begin
            field_next = csw_pkg::MODE_SEL_WAKE;
            op_next    = csw_pkg::OP_WAKE;
            sel_next   = !err_next;
          end else begin
            field_next = csw_pkg::MODE_WAKE;
            op_next    = csw_pkg::OP_WAKE;
            sel_next   = 1'b0;
          end
        end else if (GO_RESTART) begin
          pwr_next = csw_pkg::CSW_PWR_RESTART;
          cfg_next = 1'b0;
          sel_next = 1'b0;
          if (field_off) begin
            op_next = csw_pkg::OP_OFF;
          end else if (field_reg[csw_pkg::SEL_BIT]) begin
            field_next = csw_pkg::MODE_SEL_WAKE;
            op_next    = csw_pkg::OP_WAKE;
            err_set    = 1'b1;
          end else begin
            field_next = csw_pkg::MODE_WAKE;
            op_next    = csw_pkg::OP_WAKE;
          end
        end
      end

      csw_pkg::CSW_PWR_STOP: begin
        if (GO_NORMAL) begin
          pwr_next = csw_pkg::CSW_PWR_NORMAL;
        end else if (GO_SLEEP) begin
          pwr_next   = csw_pkg::CSW_PWR_SLEEP;
          rearm_next = 1'b1;
          pat_next   = 1'b0;
          frm_next   = 1'b0;
          if (field_off) begin
            op_next  = csw_pkg::OP_OFF;
            sel_next = 1'b0;
          end else begin
            field_next = field_reg[csw_pkg::SEL_BIT] ? csw_pkg::MODE_SEL_WAKE
                                                      : csw_pkg::MODE_WAKE;
            op_next    = csw_pkg::OP_WAKE;
            sel_next   = field_reg[csw_pkg::SEL_BIT] && !err_next;
          end
        end
      end

      csw_pkg::CSW_PWR_SLEEP: begin
        if (wake_any) begin
          pwr_next = csw_pkg::CSW_PWR_RESTART;
          cfg_next = 1'b0;
        end
        if (WAKE_FRAME && sel_reg) begin
          bus_next = 1'b1;
          frm_next = 1'b1;
          pat_next = SILENCE_EXPIRED;
        end else if (ERR_OVERFLOW && sel_reg) begin
          err_set  = 1'b1;
          bus_next = 1'b1;
          frm_next = 1'b0;
          cnt_next = csw_pkg::CNT_OVERFLOW;
        end else if (WAKE_PATTERN && !sel_reg && !field_off) begin
          bus_next = 1'b1;
          pat_next = 1'b1;
          frm_next = 1'b0;
        end else if (wake_any) begin
          if (field_sel) begin
            err_set = 1'b1;
          end
        end
        if (wake_any) begin
          sel_next = 1'b0;
        end
      end

      csw_pkg::CSW_PWR_RESTART: begin
        if (GO_NORMAL) begin
          pwr_next = csw_pkg::CSW_PWR_NORMAL;
          op_next  = field_reg[1:0];
          sel_next = 1'b0;
        end
      end

      default: begin
        pwr_next = csw_pkg::CSW_PWR_NORMAL;
      end
    endcase

    if (err_set) begin
      err_next = 1'b1;
      sel_next = 1'b0;
    end
  end

  // State registers update on the transition edge
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pwr_reg   <= csw_pkg::CSW_PWR_NORMAL;
      field_reg <= csw_pkg::MODE_RESET;
      op_reg    <= csw_pkg::OP_OFF;
      sel_reg   <= 1'b0;
      rearm_reg <= 1'b0;
      err_reg   <= 1'b0;
      cfg_reg   <= 1'b0;
      bus_reg   <= 1'b0;
      pat_reg   <= 1'b0;
      frm_reg   <= 1'b0;
      cnt_reg   <= csw_pkg::CNT_RESET;
    end else begin
      pwr_reg   <= pwr_next;
      field_reg <= field_next;
      op_reg    <= op_next;
      sel_reg   <= sel_next;
      rearm_reg <= rearm_next;
      err_reg   <= err_next;
      cfg_reg   <= cfg_next;
      bus_reg   <= bus_next;
      pat_reg   <= pat_next;
      frm_reg   <= frm_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Outputs straight from registers
  assign POWER_MODE    = pwr_reg;
  assign MODE_FIELD    = field_reg;
  assign XCVR_OP       = op_reg;
  assign XCVR_SEL_WAKE = sel_reg;
  assign XCVR_REARM    = rearm_reg;
  assign SEL_WAKE_ERR  = err_reg;
  assign CONFIG_VALID  = cfg_reg;
  assign BUS_WAKE      = bus_reg;
  assign WAKE_PAT      = pat_reg;
  assign WAKE_FRM      = frm_reg;
  assign ERR_COUNT     = cnt_reg;

endmodule : csw_mode_ctrl // csw_mode_ctrl

`default_nettype wire

//--- dv/csw_mode_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Mode mapping and wake flag checks at the block ports
module csw_mode_chk (
  // Clock, reset and requests
  input wire logic       CLK, RST_N, GO_STOP, GO_SLEEP, GO_RESTART, MODE_WR,
  input wire logic       WAKE_PATTERN, WAKE_FRAME, ERR_OVERFLOW, OTHER_WAKE, SILENCE_EXPIRED,
  // Observed state
  input wire logic [1:0] POWER_MODE, XCVR_OP,
  input wire logic [2:0] MODE_FIELD,
  input wire logic       XCVR_SEL_WAKE, XCVR_REARM, SEL_WAKE_ERR, CONFIG_VALID,
  input wire logic       BUS_WAKE, WAKE_PAT, WAKE_FRM,
  input wire logic [5:0] ERR_COUNT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic nrm, slp, k;
  // Normal without a same-cycle write, Sleep, and a non-off mode
  assign nrm = POWER_MODE == 2'h0 && !MODE_WR;
  assign slp = POWER_MODE == 2'h2;
  assign k   = |MODE_FIELD[1:0];
  a_stop_keep_mode: assert property (nrm && GO_STOP |=> POWER_MODE == 2'h1 &&
    MODE_FIELD == $past(MODE_FIELD) && XCVR_OP == $past(MODE_FIELD[1:0])) else $error("stop");
  a_stop_sel_wake: assert property (nrm && GO_STOP |=>
    XCVR_SEL_WAKE == $past(MODE_FIELD[2] && k && !SEL_WAKE_ERR)) else $error("stop swk");
  a_err_blocks_frames: assert property (SEL_WAKE_ERR |-> !XCVR_SEL_WAKE)
    else $error("swk");
  a_sleep_map_mode: assert property (nrm && GO_SLEEP && !GO_STOP |=> slp &&
    MODE_FIELD == {$past(MODE_FIELD[2]), 1'b0, $past(k)} && XCVR_OP == {1'b0, $past(k)})
    else $error("sleep");
  a_sleep_rearm: assert property (nrm && GO_SLEEP && !GO_STOP && k |=> XCVR_REARM)
    else $error("rearm");
  a_restart_map_mode: assert property (nrm && GO_RESTART && !GO_SLEEP &&
    !GO_STOP && !SEL_WAKE_ERR |=> POWER_MODE == 2'h3 && !XCVR_SEL_WAKE && !CONFIG_VALID &&
    MODE_FIELD == {$past(MODE_FIELD[2]), 1'b0, $past(k)} && XCVR_OP == {1'b0, $past(k)} &&
    SEL_WAKE_ERR == $past(MODE_FIELD[2] && k)) else $error("restart");
  a_frame_wake_flags: assert property (slp && WAKE_FRAME && XCVR_SEL_WAKE &&
    !ERR_OVERFLOW && !OTHER_WAKE && !WAKE_PATTERN |=> POWER_MODE == 2'h3 && BUS_WAKE &&
    WAKE_FRM && !SEL_WAKE_ERR && !CONFIG_VALID && MODE_FIELD == 3'h5 &&
    WAKE_PAT == $past(SILENCE_EXPIRED)) else $error("wuf");
  a_overflow_wake: assert property (slp && ERR_OVERFLOW && XCVR_SEL_WAKE &&
    !WAKE_FRAME && !OTHER_WAKE |=> SEL_WAKE_ERR && BUS_WAKE && !WAKE_FRM &&
    ERR_COUNT == 6'h20) else $error("ovf");
  a_pattern_wake: assert property (slp && WAKE_PATTERN && XCVR_OP == 2'h1 &&
    !XCVR_SEL_WAKE && !WAKE_FRAME && !ERR_OVERFLOW && !OTHER_WAKE |=> POWER_MODE == 2'h3 &&
    BUS_WAKE && WAKE_PAT && !WAKE_FRM && $stable(MODE_FIELD) && $stable(SEL_WAKE_ERR))
    else $error("wup");
  a_other_wake_keep: assert property (slp && OTHER_WAKE && !WAKE_PATTERN &&
    !WAKE_FRAME && !ERR_OVERFLOW |=> POWER_MODE == 2'h3 && $stable(BUS_WAKE) &&
    $stable(XCVR_OP) && $stable(MODE_FIELD)) else $error("other");
  a_no_false_wake: assert property (slp && !OTHER_WAKE && !XCVR_SEL_WAKE &&
    !(k && WAKE_PATTERN) |=> slp) else $error("false wake");
  // Main scenarios reached
  c_stop_sel: cover property (nrm && GO_STOP && MODE_FIELD[2] && k);
  c_frame: cover property (slp && WAKE_FRAME && XCVR_SEL_WAKE);
  c_ovf: cover property (slp && ERR_OVERFLOW && XCVR_SEL_WAKE);
  c_frame_ignored: cover property (slp && WAKE_FRAME && !XCVR_SEL_WAKE);
endmodule : csw_mode_chk
bind csw_mode_ctrl csw_mode_chk i_csw_mode_chk (.CLK, .RST_N, .GO_STOP, .GO_SLEEP,
  .GO_RESTART, .MODE_WR, .WAKE_PATTERN, .WAKE_FRAME, .ERR_OVERFLOW, .OTHER_WAKE,
  .SILENCE_EXPIRED, .POWER_MODE, .XCVR_OP, .MODE_FIELD, .XCVR_SEL_WAKE, .XCVR_REARM,
  .SEL_WAKE_ERR, .CONFIG_VALID, .BUS_WAKE, .WAKE_PAT, .WAKE_FRM, .ERR_COUNT);
`default_nettype wire

//--- dv/csw_bus_node.sv
`timescale 1ns/1ps
`default_nettype none
// Far bus node: sends wake patterns, wake frames, error bursts
module csw_bus_node (
  // Timing
  input  wire logic clk,
  // Wake events
  output var logic  pat, frm, ovf, sil
);
  // Quiet bus between events
  initial {pat, frm, ovf, sil} = 4'h0;
  // One event for one cycle: 0 pattern, 1 frame, 2 overflow
  task automatic send(input logic [1:0] k, input logic s);
    @(posedge clk);
    #1 {pat, frm, ovf, sil} = {k == 2'h0, k == 2'h1, k == 2'h2, s};
    @(posedge clk);
    #1 {pat, frm, ovf, sil} = 4'h0;
  endtask
endmodule : csw_bus_node
`default_nettype wire

//--- dv/tb_csw_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module tb_csw_mode_ctrl;
  // Host pulse codes
  localparam logic [9:0] STP = 10'h200, SLP = 10'h100, RS = 10'h080, NRM = 10'h040;
  localparam logic [9:0] WR = 10'h020, CV = 10'h010, CHG = 10'h008, CLR = 10'h006;
  localparam logic [9:0] OTH = 10'h001;
  logic       CLK = 1'b0, RST_N = 1'b0;
  logic [9:0] hp = 10'h000;
  logic [2:0] mwd = 3'h0, MODE_FIELD;
  logic [1:0] POWER_MODE, XCVR_OP;
  logic [5:0] ERR_COUNT;
  logic       XCVR_SEL_WAKE, XCVR_REARM, SEL_WAKE_ERR, CONFIG_VALID, BUS_WAKE, WAKE_PAT;
  logic       WAKE_FRM, pat, frm, ovf, sil;
  int         n_fail = 0, checked = 0, cyc = 0;
  logic [4:0] wake_view;
  logic [6:0] flag_view;
  logic [7:0] mode_view;
  // Grouped outputs for compact compares
  assign wake_view = {POWER_MODE == 2'h3, BUS_WAKE, WAKE_PAT, WAKE_FRM, SEL_WAKE_ERR};
  assign flag_view = {XCVR_SEL_WAKE, XCVR_REARM, SEL_WAKE_ERR, CONFIG_VALID, BUS_WAKE,
                      WAKE_PAT, WAKE_FRM};
  assign mode_view = {POWER_MODE, MODE_FIELD, XCVR_OP, XCVR_SEL_WAKE};
  csw_mode_ctrl i_csw_mode_ctrl (.CLK, .RST_N, .GO_STOP(hp[9]), .GO_SLEEP(hp[8]),
    .GO_RESTART(hp[7]), .GO_NORMAL(hp[6]), .MODE_WR(hp[5]), .MODE_WDATA(mwd),
    .CFG_VALID_SET(hp[4]), .CFG_CHANGED(hp[3]), .ERR_CLR(hp[2]), .WAKE_FLAGS_CLR(hp[1]),
    .WAKE_PATTERN(pat), .WAKE_FRAME(frm), .ERR_OVERFLOW(ovf), .OTHER_WAKE(hp[0]),
    .SILENCE_EXPIRED(sil), .POWER_MODE, .MODE_FIELD, .XCVR_OP, .XCVR_SEL_WAKE, .XCVR_REARM,
    .SEL_WAKE_ERR, .CONFIG_VALID, .BUS_WAKE, .WAKE_PAT, .WAKE_FRM, .ERR_COUNT);
  csw_bus_node i_csw_bus_node (.clk(CLK), .pat, .frm, .ovf, .sil);
  // Clock and hang guard
  always #50 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      final_report;
    end
  end
  // One host pulse, outputs settled on return
  task automatic cmd(input logic [9:0] p, input logic [2:0] d);
    @(posedge CLK);
    #1 hp = p;
    mwd = d;
    @(posedge CLK);
    #1 hp = 10'h000;
  endtask
  // Program a mode from a clean Normal state, setup valid or stale
  task automatic arm(input logic [2:0] c, input logic e);
    cmd(WR, 3'h0);
    cmd(CLR, 3'h0);
    if (e) cmd(CHG, 3'h0);
    cmd(e ? WR : WR | CV, c);
  endtask
  // Sleep, one bus event, then flags {restart, bus, pattern, frame, error}
  task automatic wk(input logic [2:0] c, input logic e, input logic [1:0] k, input logic s,
                    input logic [4:0] x);
    arm(c, e);
    cmd(SLP, 3'h0);
    i_csw_bus_node.send(k, s);
    `CHK("wake", x, wake_view & {2'h3, k != 2'h2, 2'h3})
    if (x[4]) `CHK("wfld", {c[2], 1'b0, 1'b1}, MODE_FIELD)
    if (x[4]) `CHK("wcfg", 1'b0, CONFIG_VALID)
    if (k == 2'h2) `CHK("cnt", 6'h20, ERR_COUNT)
    if (!x[4]) cmd(OTH, 3'h0);
    cmd(NRM, 3'h0);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Reset, mode maps for Stop, Sleep and Restart, then wake reasons
  initial begin
    logic [2:0] c;
    logic       k, s;
    repeat (5) @(posedge CLK);
    #1 RST_N = 1'b1;
    `CHK("reset", 7'h00, {POWER_MODE, MODE_FIELD, XCVR_OP})
    `CHK("rflags", 13'h0000, {flag_view, ERR_COUNT})
    for (int m = 0; m < 3; m++) begin
      for (int e = 0; e < 2; e++) begin
        for (int i = 0; i < 8; i++) begin
          c = i[2:0];
          k = |c[1:0];
          s = c[2] && k && e == 0;
          arm(c, e[0]);
          `CHK("wrearm", c != 3'h0, XCVR_REARM)
          // Error clear is refused while a selective mode lacks valid setup
          if (e == 1) cmd(CLR, 3'h0);
          if (k) `CHK("err", c[2] && e[0], SEL_WAKE_ERR)
          cmd(m == 0 ? STP : m == 1 ? SLP : RS, 3'h0);
          `CHK("pwr", m == 0 ? 2'h1 : m == 1 ? 2'h2 : 2'h3, POWER_MODE)
          `CHK("fld", m == 0 ? c : {c[2], 1'b0, k}, MODE_FIELD)
          `CHK("op", m == 0 ? c[1:0] : {1'b0, k}, XCVR_OP)
          `CHK("swk", m == 2 ? 1'b0 : s, XCVR_SEL_WAKE)
          if (m == 2 && k) `CHK("err2", c[2], SEL_WAKE_ERR)
          if (m == 1 && k) `CHK("rearm", 1'b1, XCVR_REARM)
          // Stop to Sleep uses the same mapping as Normal to Sleep
          if (m == 0 && e == 1) begin
            cmd(SLP, 3'h0);
            `CHK("stslp", {2'h2, c[2], 1'b0, k, 1'b0, k, s}, mode_view)
          end
          if (m == 1 || (m == 0 && e == 1)) begin
            cmd(OTH, 3'h0);
            `CHK("oth", {2'h3, 1'b0, c[2], 1'b0, k}, {POWER_MODE, BUS_WAKE, MODE_FIELD})
            `CHK("cfg", 1'b0, CONFIG_VALID)
          end
          cmd(NRM, 3'h0);
        end
      end
      $display("test mode map %0d done", m);
    end
    wk(3'h5, 1'b0, 2'h1, 1'b1, 5'h1e);
    wk(3'h6, 1'b0, 2'h1, 1'b0, 5'h1a);
    wk(3'h7, 1'b0, 2'h2, 1'b0, 5'h19);
    wk(3'h1, 1'b0, 2'h0, 1'b0, 5'h1c);
    wk(3'h5, 1'b1, 2'h0, 1'b0, 5'h1d);
    wk(3'h5, 1'b1, 2'h1, 1'b1, 5'h01);
    $display("test wake reasons done");
    final_report;
  end
endmodule : tb_csw_mode_ctrl
`default_nettype wire
